/* rtl/rtsd_ramp.sv */
// Frequency ramp with dwell, ramp time pair selection and latched fast stop
`timescale 1ns/10ps

// What this block does
// - On acceleration, hold at start dwell frequency for start dwell time.
// - On deceleration, hold at stop dwell frequency for stop dwell time.
// - Acceleration time means zero to maximum frequency; slope scales.
// - Deceleration time means maximum frequency down to zero.
// - Ramp times default 10.0 s, range up to 6000.0 s or 600.00 s.
// - Pair 1 is used when nothing else selects.
// - Two selector inputs pick pairs 1 to 4, low selector first.
// - Motor input picks motor 2 when closed, never under PM control.
// - With motor select, one selector picks pairs 1/2 or 3/4.
// - Nonzero switch frequency: pair 4 below it, pair 1 at or above.
// - Motor 2 with switch frequency: pair 4 below, pair 3 above.
// - Selector inputs override switching by frequency level.
// - Fast-stop input, open or closed active, latches a fast stop.
// - After fast stop, restart needs stop done, input released, run cycled.
// - Fast-stop status output is on while fast stop runs.
// - Fault-triggered fast stop decelerates with the fast stop time.
// - Fast stop time defaults 10.0 s, same range as ramp times.
// - Time unit 0 means 0.01 s steps, 1 means 0.1 s, default 1.
module rtsd_ramp #(
  parameter int TICK_CYCLES_P = rtsd_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 rst_n,
  // Terminals, asynchronous
  input  wire rtsd_pkg::rtsd_pins_s pins_async,
  // Drive internals, same clock
  input  wire logic                 fault_fast_stop,
  input  wire logic [15:0]          freq_target,
  input  wire rtsd_pkg::rtsd_cfg_s  cfg,
  input  wire rtsd_pkg::rtsd_times_s times_in,
  input  wire logic                 times_load,
  // Status
  output logic [15:0]               freq_ref_reg,
  output logic [1:0]                pair_reg,
  output logic                      fast_stop_out_reg,
  output logic                      restart_lock_reg,
  output logic                      dwell_reg
);

  localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES_P - 1);

  logic [5:0]            sync1_reg;
  logic [5:0]            sync2_reg;
  rtsd_pkg::rtsd_pins_s  pin;
  logic [15:0]           tick_cnt_reg;
  logic                  tick;
  rtsd_pkg::rtsd_times_s times_reg;
  rtsd_pkg::rtsd_state_e state_reg;
  rtsd_pkg::rtsd_state_e state_next;
  logic [13:0]           dwell_cnt_reg;
  logic [25:0]           err_reg;
  logic [25:0]           err_next;
  logic [15:0]           freq_next;
  logic [15:0]           goal;
  logic [15:0]           tgt;
  logic [15:0]           rate_t;
  logic [22:0]           ramp_ticks;
  logic [1:0]            pair_next;
  logic                  motor_sw;
  logic                  motor2;
  logic                  sel_asg;
  logic                  fs_held;
  logic                  fs_trig;
  logic                  moving;
  logic                  up;
  logic                  sd_en;
  logic                  pd_en;
  logic                  in_dwell_next;

  // Terminal synchronisers
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sync1_reg <= rtsd_pkg::PINS_IDLE;
      sync2_reg <= rtsd_pkg::PINS_IDLE;
    end else begin
      sync1_reg <= pins_async;
      sync2_reg <= sync1_reg;
    end
  end

  assign pin = rtsd_pkg::rtsd_pins_s'(sync2_reg);

  // Control tick
  always_ff @(posedge ref_clk) begin
    if (!rst_n || tick) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 16'h0001;
    end
  end

  assign tick = (tick_cnt_reg == TICK_LAST);

  // Ramp time settings, held so that reset gives the defaults
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      times_reg <= rtsd_pkg::rtsd_times_s'(rtsd_pkg::TIMES_RESET);
    end else if (times_load) begin
      times_reg <= times_in;
    end
  end

  // Ramp time pair selection
  assign motor_sw = cfg.asg_motor && !cfg.pm_control;
  assign motor2   = motor_sw && pin.motor2;
  assign sel_asg  = cfg.asg_sel_lo || cfg.asg_sel_hi;

  always_comb begin
    pair_next = {motor2, 1'b0};
    if (sel_asg) begin
      if (motor_sw) begin
        pair_next = {motor2, cfg.asg_sel_lo && pin.sel_lo};
      end else begin
        pair_next = {cfg.asg_sel_hi && pin.sel_hi, cfg.asg_sel_lo && pin.sel_lo};
      end
    end else if (cfg.switch_f != '0) begin
      if (freq_ref_reg < cfg.switch_f) begin
        pair_next = rtsd_pkg::PAIR_4;
      end else begin
        pair_next = {motor2, 1'b0};
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pair_reg <= rtsd_pkg::PAIR_1;
    end else begin
      pair_reg <= pair_next;
    end
  end

  // Fast-stop request from terminals or fault reaction
  assign fs_held = (cfg.asg_fs_no && pin.fs_no) || (cfg.asg_fs_nc && !pin.fs_nc);
  assign fs_trig = fs_held || fault_fast_stop;

  // Frequency beyond the maximum is clipped so the slope stays defined
  assign tgt   = !pin.run ? '0 : (freq_target > cfg.max_f) ? cfg.max_f : freq_target;
  assign sd_en = (cfg.start_t != '0) && (cfg.start_f < tgt);
  assign pd_en = (cfg.stop_t != '0) && (freq_ref_reg >= cfg.stop_f);

  // Sequencer
  always_comb begin
    state_next = state_reg;
    goal       = '0;
    case (state_reg)
      rtsd_pkg::ST_STOPPED: begin
        if (pin.run && !restart_lock_reg && !fs_trig) begin
          state_next = rtsd_pkg::ST_ACCEL;
        end
      end
      rtsd_pkg::ST_ACCEL: begin
        goal = sd_en ? cfg.start_f : tgt;
        if (!pin.run) begin
          // Freeze one cycle so the stop dwell decision still sees the running frequency
          goal       = freq_ref_reg;
          state_next = rtsd_pkg::ST_DECEL;
        end else if (freq_ref_reg == goal) begin
          state_next = sd_en ? rtsd_pkg::ST_SDWELL : rtsd_pkg::ST_TRACK;
        end
      end
      rtsd_pkg::ST_SDWELL: begin
        goal = freq_ref_reg;
        if (!pin.run) begin
          state_next = rtsd_pkg::ST_DECEL;
        end else if (dwell_cnt_reg == '0) begin
          state_next = rtsd_pkg::ST_TRACK;
        end
      end
      rtsd_pkg::ST_TRACK: begin
        goal = tgt;
        if (!pin.run) begin
          goal       = freq_ref_reg;
          state_next = rtsd_pkg::ST_DECEL;
        end
      end
      rtsd_pkg::ST_DECEL: begin
        goal = pd_en ? cfg.stop_f : '0;
        if (pin.run) begin
          state_next = rtsd_pkg::ST_TRACK;
        end else if (pd_en && freq_ref_reg == cfg.stop_f) begin
          state_next = rtsd_pkg::ST_PDWELL;
        end else if (freq_ref_reg == '0) begin
          state_next = rtsd_pkg::ST_STOPPED;
        end
      end
      rtsd_pkg::ST_PDWELL: begin
        goal = freq_ref_reg;
        if (pin.run) begin
          state_next = rtsd_pkg::ST_TRACK;
        end else if (dwell_cnt_reg == '0) begin
          state_next = rtsd_pkg::ST_FINAL;
        end
      end
      rtsd_pkg::ST_FINAL: begin
        if (pin.run) begin
          state_next = rtsd_pkg::ST_TRACK;
        end else if (freq_ref_reg == '0) begin
          state_next = rtsd_pkg::ST_STOPPED;
        end
      end
      rtsd_pkg::ST_FAST: begin
        // Run is ignored here; only reaching zero ends the fast stop
        if (freq_ref_reg == '0) begin
          state_next = rtsd_pkg::ST_STOPPED;
        end
      end
      default: begin
        state_next = rtsd_pkg::ST_STOPPED;
      end
    endcase
    if (fs_trig && state_reg != rtsd_pkg::ST_STOPPED && state_reg != rtsd_pkg::ST_FAST) begin
      state_next = rtsd_pkg::ST_FAST;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_reg <= rtsd_pkg::ST_STOPPED;
    end else begin
      state_reg <= state_next;
    end
  end

  // Restart lock; a new request wins over the clear
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      restart_lock_reg <= 1'b0;
    end else if (fs_trig) begin
      restart_lock_reg <= 1'b1;
    end else if (state_reg == rtsd_pkg::ST_STOPPED && !pin.run) begin
      restart_lock_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      fast_stop_out_reg <= 1'b0;
    end else begin
      fast_stop_out_reg <= (state_next == rtsd_pkg::ST_FAST);
    end
  end

  // Dwell timer, loaded on entry and counted in control ticks
  assign in_dwell_next = (state_next == rtsd_pkg::ST_SDWELL) || (state_next == rtsd_pkg::ST_PDWELL);

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      dwell_cnt_reg <= '0;
    end else if (state_next == rtsd_pkg::ST_SDWELL && state_reg != rtsd_pkg::ST_SDWELL) begin
      dwell_cnt_reg <= ((cfg.start_t > rtsd_pkg::DWELL_TIME_MAX) ? rtsd_pkg::DWELL_TIME_MAX : cfg.start_t)
                       * rtsd_pkg::TPU_DWELL;
    end else if (state_next == rtsd_pkg::ST_PDWELL && state_reg != rtsd_pkg::ST_PDWELL) begin
      dwell_cnt_reg <= ((cfg.stop_t > rtsd_pkg::DWELL_TIME_MAX) ? rtsd_pkg::DWELL_TIME_MAX : cfg.stop_t)
                       * rtsd_pkg::TPU_DWELL;
    end else if (tick && dwell_cnt_reg != '0) begin
      dwell_cnt_reg <= dwell_cnt_reg - 14'h0001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      dwell_reg <= 1'b0;
    end else begin
      dwell_reg <= in_dwell_next;
    end
  end

  // Ramp time in control ticks
  assign moving = (freq_ref_reg != goal);
  assign up     = (goal > freq_ref_reg);

  always_comb begin
    if (state_reg == rtsd_pkg::ST_FAST) begin
      rate_t = times_reg.fast_t;
    end else if (up) begin
      rate_t = times_reg.accel_t[pair_reg];
    end else begin
      rate_t = times_reg.decel_t[pair_reg];
    end
    if (rate_t > rtsd_pkg::RAMP_TIME_MAX) begin
      rate_t = rtsd_pkg::RAMP_TIME_MAX;
    end
  end

  assign ramp_ticks = rate_t * (times_reg.unit_coarse ? rtsd_pkg::TPU_COARSE : rtsd_pkg::TPU_FINE);

  // Error accumulator: each tick earns max_f, each step of one count costs the ramp time.
  // At most one count per clock; the tick period leaves ample clocks to pay off.
  always_comb begin
    freq_next = freq_ref_reg;
    err_next  = '0;
    if (moving) begin
      if (ramp_ticks == '0) begin
        freq_next = goal;
      end else begin
        err_next = err_reg + (tick ? 26'(cfg.max_f) : '0);
        if (err_reg >= 26'(ramp_ticks)) begin
          err_next  = err_next - 26'(ramp_ticks);
          freq_next = up ? freq_ref_reg + rtsd_pkg::FREQ_STEP : freq_ref_reg - rtsd_pkg::FREQ_STEP;
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      freq_ref_reg <= '0;
      err_reg      <= '0;
    end else begin
      freq_ref_reg <= freq_next;
      err_reg      <= err_next;
    end
  end

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_sdwell_two;
    state_reg == rtsd_pkg::ST_SDWELL [*2];
  endsequence
  sequence s_pdwell_two;
    state_reg == rtsd_pkg::ST_PDWELL [*2];
  endsequence

  a_start_dwell_hold: assert property (s_sdwell_two |-> $stable(freq_ref_reg))
    else $error("frequency moved during start dwell");
  a_stop_dwell_hold: assert property (s_pdwell_two |-> $stable(freq_ref_reg))
    else $error("frequency moved during stop dwell");
  a_dwell_entry: assert property (state_reg == rtsd_pkg::ST_ACCEL && pin.run && !fs_trig && sd_en
    && freq_ref_reg == cfg.start_f |=> state_reg == rtsd_pkg::ST_SDWELL)
    else $error("start dwell not entered at dwell frequency");
  a_fast_entry: assert property (fs_trig && state_reg != rtsd_pkg::ST_STOPPED
    && !(state_reg == rtsd_pkg::ST_FAST && freq_ref_reg == '0)
    |=> state_reg == rtsd_pkg::ST_FAST && restart_lock_reg)
    else $error("fast stop not latched");
  a_fast_status: assert property (fast_stop_out_reg == (state_reg == rtsd_pkg::ST_FAST))
    else $error("fast stop status wrong");
  a_restart_lock: assert property (restart_lock_reg && state_reg == rtsd_pkg::ST_STOPPED
    |=> state_reg == rtsd_pkg::ST_STOPPED)
    else $error("restart while locked");
  a_fault_rate: assert property (fault_fast_stop && state_reg != rtsd_pkg::ST_STOPPED
    && !(state_reg == rtsd_pkg::ST_FAST && freq_ref_reg == '0)
    |=> state_reg == rtsd_pkg::ST_FAST ##0 rate_t == times_reg.fast_t)
    else $error("fault fast stop not using fast stop time");
  a_pair_select: assert property (sel_asg && !motor_sw
    |=> pair_reg == {$past(cfg.asg_sel_hi) && $past(pin.sel_hi), $past(cfg.asg_sel_lo) && $past(pin.sel_lo)})
    else $error("selector pair wrong");
  a_pair_level: assert property (!sel_asg && cfg.switch_f != '0 && freq_ref_reg < cfg.switch_f
    |=> pair_reg == rtsd_pkg::PAIR_4)
    else $error("pair 4 not used below switch frequency");
  a_pair_default: assert property (!sel_asg && cfg.switch_f == '0 && !motor2
    |=> pair_reg == rtsd_pkg::PAIR_1)
    else $error("default pair not used");
  a_step_size: assert property (moving && ramp_ticks != '0
    |=> freq_ref_reg == $past(freq_ref_reg) || freq_ref_reg == $past(freq_ref_reg) + rtsd_pkg::FREQ_STEP
        || freq_ref_reg == $past(freq_ref_reg) - rtsd_pkg::FREQ_STEP)
    else $error("ramp step larger than one count");

endmodule

/* rtl/rtsd_pkg.sv */
// Constants, states and carrier types of the ramp time select, dwell and fast-stop block
package rtsd_pkg;

  // Clock and control tick
  localparam int CLK_HZ         = 25_000_000;
  localparam int TICK_TIME_US   = 1000;
  localparam int TICK_CYCLES    = CLK_HZ / 1_000_000 * TICK_TIME_US;

  // Time units of the settings, in microseconds
  localparam int UNIT_FINE_US   = 10_000;
  localparam int UNIT_COARSE_US = 100_000;
  localparam int DWELL_UNIT_US  = 100_000;

  // Control ticks per setting unit
  localparam logic [6:0]  TPU_FINE   = 7'(UNIT_FINE_US / TICK_TIME_US);
  localparam logic [6:0]  TPU_COARSE = 7'(UNIT_COARSE_US / TICK_TIME_US);
  localparam logic [6:0]  TPU_DWELL  = 7'(DWELL_UNIT_US / TICK_TIME_US);

  // Setting limits and defaults (dwell in 0.1 s, ramp in the selected unit)
  localparam logic [6:0]  DWELL_TIME_MAX    = 7'h64;
  localparam logic [15:0] RAMP_TIME_MAX     = 16'hEA60;
  localparam logic [15:0] RAMP_TIME_DEFAULT = 16'h0064;
  localparam logic        UNIT_DEFAULT      = 1'b1;

  // Ramp time pairs 1 and 4 and frequency step (0.01 Hz)
  localparam logic [1:0]  PAIR_1    = 2'h0;
  localparam logic [1:0]  PAIR_4    = 2'h3;
  localparam logic [15:0] FREQ_STEP = 16'h0001;

  typedef enum logic [2:0] {
    ST_STOPPED = 3'b000,
    ST_ACCEL   = 3'b001,
    ST_SDWELL  = 3'b011,
    ST_TRACK   = 3'b010,
    ST_DECEL   = 3'b110,
    ST_PDWELL  = 3'b111,
    ST_FINAL   = 3'b101,
    ST_FAST    = 3'b100
  } rtsd_state_e;

  // Terminal levels, high means closed
  typedef struct packed {
    logic run;
    logic sel_lo;
    logic sel_hi;
    logic motor2;
    logic fs_no;
    logic fs_nc;
  } rtsd_pins_s;

  // Released terminals; the normally closed fast-stop input idles closed
  localparam logic [5:0] PINS_IDLE = 6'h01;

  typedef struct packed {
    logic        asg_sel_lo;
    logic        asg_sel_hi;
    logic        asg_motor;
    logic        asg_fs_no;
    logic        asg_fs_nc;
    logic        pm_control;
    logic [15:0] max_f;
    logic [15:0] start_f;
    logic [15:0] stop_f;
    logic [15:0] switch_f;
    logic [6:0]  start_t;
    logic [6:0]  stop_t;
  } rtsd_cfg_s;

  typedef struct packed {
    logic             unit_coarse;
    logic [3:0][15:0] accel_t;
    logic [3:0][15:0] decel_t;
    logic [15:0]      fast_t;
  } rtsd_times_s;

  localparam logic [144:0] TIMES_RESET = {UNIT_DEFAULT, {9{RAMP_TIME_DEFAULT}}};

endpackage

/* sim/rtsd_term_model.sv */
// Model of the digital input terminals and the run command source
`timescale 1ns/10ps
module rtsd_term_model (
  // Commands from the bench
  input  wire logic            run_cmd,
  input  wire logic            sel_lo,
  input  wire logic            sel_hi,
  input  wire logic            motor2,
  input  wire logic            fs_no,
  input  wire logic            fs_nc_open,
  // Terminal levels, high means closed
  output rtsd_pkg::rtsd_pins_s pins
);
  // Contacts are always driven, so no released level exists here
  // The run command is only cycled once a fast stop has ended
  // Stopping method is fixed at ramp-to-stop, so stop dwell is legal
  assign pins = {run_cmd, sel_lo, sel_hi, motor2, fs_no, ~fs_nc_open};
endmodule

/* sim/rtsd_ramp_bench.sv */
// Self-checking bench for the ramp, dwell, pair select and fast-stop block
`timescale 1ns/10ps
module rtsd_ramp_bench;
  // Short tick keeps ramps brief; every expected length below is 20 clocks per tick
  localparam int TCP = 20;
  logic                  ref_clk = 1'b0;
  logic                  rst_n = 1'b0;
  logic                  fault_fast_stop = 1'b0;
  logic [15:0]           freq_target = 16'h0000;
  rtsd_pkg::rtsd_cfg_s   cfg = '0;
  rtsd_pkg::rtsd_times_s tms = rtsd_pkg::TIMES_RESET;
  logic                  times_load = 1'b0;
  logic                  run = 1'b0;
  logic                  s_lo = 1'b0;
  logic                  s_hi = 1'b0;
  logic                  mot = 1'b0;
  logic                  fno = 1'b0;
  logic                  fnc_open = 1'b0;
  rtsd_pkg::rtsd_pins_s  pins;
  logic [15:0]           freq_ref;
  logic [1:0]            pair;
  logic                  fs_out;
  logic                  lock;
  logic                  dwell;
  int                    bad_count = 0;
  int                    cmp_count = 0;
  int                    cyc = 0;

  rtsd_term_model term (.run_cmd(run), .sel_lo(s_lo), .sel_hi(s_hi), .motor2(mot), .fs_no(fno),
                        .fs_nc_open(fnc_open), .pins(pins));
  rtsd_ramp #(.TICK_CYCLES_P(TCP)) uut (.ref_clk(ref_clk), .rst_n(rst_n), .pins_async(pins),
    .fault_fast_stop(fault_fast_stop), .freq_target(freq_target), .cfg(cfg), .times_in(tms),
    .times_load(times_load), .freq_ref_reg(freq_ref), .pair_reg(pair), .fast_stop_out_reg(fs_out),
    .restart_lock_reg(lock), .dwell_reg(dwell));

  always #20 ref_clk = ~ref_clk;

  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Scenarios need about 9300 cycles; the ceiling leaves over three times that
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      bad_count = bad_count + 1;
      report_and_stop();
    end
  end

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic chk_rng(input string nm, input int lo, input int hi, input int n);
    cmp_count++;
    if (n < lo || n > hi) begin
      bad_count++;
      $display("Error %s expected %0d to %0d seen %0d", nm, lo, hi, n);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // Clocks until the reference shows f, bounded by lim
  task automatic wait_f(input logic [15:0] f, input int lim, output int n);
    n = 0;
    while (freq_ref !== f && n < lim) begin
      @(negedge ref_clk);
      n++;
    end
  endtask

  task automatic load(input logic u, input logic [15:0] t, input logic [15:0] ft);
    tms.unit_coarse = u;
    for (int i = 0; i < 4; i++) begin
      tms.accel_t[i] = t;
      tms.decel_t[i] = t;
    end
    tms.fast_t = ft;
    times_load = 1'b1;
    step(1);
    times_load = 1'b0;
  endtask

  task automatic t_reset();
    chk("freq_ref", 16'h0000, freq_ref);
    chk("pair", 16'h0000, 16'(pair));
    chk("flags", 16'h0000, {13'h0000, fs_out, lock, dwell});
  endtask

  // Default 10.0 s in 0.1 s units: first count after 100 ticks
  task automatic t_default();
    int n;
    freq_target = 16'h0064;
    run = 1'b1;
    step(1900);
    chk("freq_ref", 16'h0000, freq_ref);
    wait_f(16'h0001, 300, n);
    chk_rng("first_step", 80, 110, n);
    load(1'b0, 16'h0000, 16'h0000);
    run = 1'b0;
    wait_f(16'h0000, 50, n);
    chk("freq_ref", 16'h0000, freq_ref);
  endtask

  // Time 1: full span 10 ticks fine, 100 ticks coarse; 55 counts take 5.5 or 55 ticks
  task automatic t_ramp();
    int n;
    load(1'b0, 16'h0001, 16'h0001);
    freq_target = 16'h0037;
    run = 1'b1;
    wait_f(16'h0037, 400, n);
    chk_rng("accel_len", 100, 135, n);
    step(40);
    chk("freq_ref", 16'h0037, freq_ref);
    run = 1'b0;
    wait_f(16'h0000, 400, n);
    chk_rng("decel_len", 100, 135, n);
    load(1'b1, 16'h0001, 16'h0001);
    run = 1'b1;
    wait_f(16'h0037, 2000, n);
    chk_rng("coarse_len", 1075, 1110, n);
    run = 1'b0;
    wait_f(16'h0000, 2000, n);
  endtask

  // Dwell of 0.1 s is 100 ticks
  task automatic t_dwell();
    int n;
    load(1'b0, 16'h0000, 16'h0000);
    cfg.start_f = 16'h0028;
    cfg.stop_f = 16'h001E;
    cfg.start_t = 7'h01;
    cfg.stop_t = 7'h01;
    freq_target = 16'h0050;
    run = 1'b1;
    step(8);
    chk("dwell", 16'h0001, 16'(dwell));
    chk("freq_ref", 16'h0028, freq_ref);
    wait_f(16'h0050, 2100, n);
    chk_rng("start_hold", 1975, 2030, n);
    run = 1'b0;
    step(8);
    chk("freq_ref", 16'h001E, freq_ref);
    wait_f(16'h0000, 2100, n);
    chk_rng("stop_hold", 1975, 2030, n);
    cfg.start_t = 7'h00;
    run = 1'b1;
    step(8);
    chk("freq_ref", 16'h0050, freq_ref);
    chk("dwell", 16'h0000, 16'(dwell));
    cfg.stop_t = 7'h00;
    run = 1'b0;
    step(8);
  endtask

  task automatic t_pairs();
    logic [1:0] i2;
    cfg.switch_f = 16'h0032;
    cfg.asg_sel_lo = 1'b1;
    cfg.asg_sel_hi = 1'b1;
    for (int i = 0; i < 4; i++) begin
      i2 = 2'(i);
      {s_hi, s_lo} = i2;
      step(4);
      chk("pair_sel", 16'(i2), 16'(pair));
    end
    cfg.asg_sel_hi = 1'b0;
    cfg.asg_motor = 1'b1;
    for (int i = 0; i < 4; i++) begin
      i2 = 2'(i);
      {mot, s_lo} = i2;
      step(4);
      chk("pair_motor", 16'(i2), 16'(pair));
    end
    cfg.pm_control = 1'b1;
    s_lo = 1'b0;
    step(4);
    chk("pair_pm", 16'h0000, 16'(pair));
    cfg.pm_control = 1'b0;
    cfg.asg_sel_lo = 1'b0;
    step(4);
    chk("pair_low", 16'h0003, 16'(pair));
    run = 1'b1;
    step(8);
    chk("pair_high_m2", 16'h0002, 16'(pair));
    mot = 1'b0;
    step(4);
    chk("pair_high", 16'h0000, 16'(pair));
    cfg.switch_f = 16'h0050;
    step(4);
    chk("pair_equal", 16'h0000, 16'(pair));
    cfg.switch_f = 16'h0000;
    cfg.asg_motor = 1'b0;
    run = 1'b0;
    step(8);
  endtask

  // Fast stop time 1 in 0.01 s: 100 counts in 10 ticks
  task automatic t_fast();
    int n;
    load(1'b0, 16'h0000, 16'h0001);
    cfg.asg_fs_no = 1'b1;
    cfg.asg_fs_nc = 1'b1;
    freq_target = 16'h0064;
    run = 1'b1;
    step(8);
    fno = 1'b1;
    step(4);
    chk("fs_out", 16'h0001, 16'(fs_out));
    wait_f(16'h0000, 400, n);
    chk_rng("fast_len", 185, 225, n);
    step(2);
    chk("fs_out", 16'h0000, 16'(fs_out));
    run = 1'b0;
    step(5);
    run = 1'b1;
    step(10);
    chk("freq_ref", 16'h0000, freq_ref);
    chk("lock", 16'h0001, 16'(lock));
    fno = 1'b0;
    step(10);
    chk("freq_ref", 16'h0000, freq_ref);
    run = 1'b0;
    step(5);
    chk("lock", 16'h0000, 16'(lock));
    run = 1'b1;
    step(8);
    chk("freq_ref", 16'h0064, freq_ref);
    fnc_open = 1'b1;
    step(1);
    fnc_open = 1'b0;
    step(4);
    chk("fs_out", 16'h0001, 16'(fs_out));
    wait_f(16'h0000, 400, n);
    chk_rng("fast_len", 185, 225, n);
    run = 1'b0;
    step(5);
    run = 1'b1;
    step(8);
    fault_fast_stop = 1'b1;
    step(1);
    fault_fast_stop = 1'b0;
    wait_f(16'h0000, 400, n);
    chk_rng("fault_len", 180, 225, n);
    run = 1'b0;
    step(5);
  endtask

  initial begin
    cfg.max_f = 16'h0064;
    step(5);
    rst_n = 1'b1;
    t_reset();
    t_default();
    t_ramp();
    t_dwell();
    t_pairs();
    t_fast();
    report_and_stop();
  end
endmodule
